// file: shared/acqrh_pkg.sv
`default_nettype none

package acqrh_pkg;

  // ************
  // Clock and timing
  // ************
  localparam int CLK_MHZ = 125;
  // Free-running wait before an untriggered capture is forced
  localparam int AUTO_WAIT_US = 100;
  localparam int AUTO_CYCLES = AUTO_WAIT_US * CLK_MHZ;
  localparam int NCH = 4;

  // ************
  // Register map (byte addresses)
  // ************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CHAN = 8'h08;
  localparam logic [7:0] ADDR_VSCALE = 8'h0c;
  localparam logic [7:0] ADDR_VPOS01 = 8'h10;
  localparam logic [7:0] ADDR_VPOS23 = 8'h14;
  localparam logic [7:0] ADDR_HSCALE = 8'h18;
  localparam logic [7:0] ADDR_TRIG_LEVEL = 8'h1c;

  // CTRL fields
  localparam int CTRL_TRIG_WAIT_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam int CTRL_HOLD_BIT = 2;
  localparam int CTRL_AUTO_BIT = 3;
  localparam int CTRL_PROBE_LSB = 4;
  localparam logic CTRL_TRIG_WAIT_RESET = 1'b0;

  // STATUS fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_RUN_LED_BIT = 3;
  localparam int STAT_AUTO_BUSY_BIT = 4;
  localparam int STAT_HELD_BIT = 5;

  // CHAN fields
  localparam int CHAN_DISP_LSB = 0;
  localparam int CHAN_DC_LSB = 4;
  localparam int CHAN_TSRC_LSB = 8;
  localparam int CHAN_EDGE_BIT = 10;
  localparam int CHAN_RISE_BIT = 11;
  localparam int CHAN_TDC_BIT = 12;
  localparam int CHAN_SECOND_BIT = 13;

  // ************
  // Scale codes (1-2-5 steps)
  // ************
  // Vertical code 0 is 2 mV/div; each probe decade adds three codes
  localparam int V_BASE_IDX = 1;
  localparam int V_PICK_CODES = 11;
  localparam logic [4:0] VCODE_DEF = 5'h05;
  localparam logic [4:0] VCODE_MAX = 5'h10;
  localparam logic [4:0] PROBE_STEP = 5'h03;
  // Horizontal code 0 is 1 ns/div
  localparam int H_BASE_IDX = 0;
  localparam int H_PICK_CODES = 27;
  localparam logic [4:0] HCODE_DEF = 5'h12;

  localparam logic [15:0] NOSIG_MV = 16'h0005;
  localparam logic [1:0] PROBE_X1 = 2'h0;
  localparam logic [1:0] PROBE_X10 = 2'h1;
  localparam logic [1:0] PROBE_X100 = 2'h2;
  localparam logic signed [15:0] LANE_POS_MV [NCH] = '{16'sh012c, 16'sh0064,
                                                      -16'sh0064, -16'sh012c};

  // ************
  // Types
  // ************
  typedef enum logic [2:0] {
    ACQ_HOLD = 3'h0,
    ACQ_RUN_ARM = 3'h1,
    ACQ_RUN_CAPT = 3'h2,
    ACQ_SNG_ARM = 3'h3,
    ACQ_SNG_CAPT = 3'h4,
    ACQ_AUTO_MEAS = 3'h5,
    ACQ_AUTO_APPLY = 3'h6
  } acqrh_state_t;

  typedef struct packed {
    logic signed [15:0] vmax;
    logic signed [15:0] vmin;
    logic signed [15:0] vavg;
    logic [31:0] period_ns;
  } acqrh_chan_meas_t;

  typedef acqrh_chan_meas_t [NCH-1:0] acqrh_meas_t;

  typedef struct packed {
    logic [NCH-1:0] disp_en;
    logic [NCH-1:0] dc_coupling;
    logic [NCH-1:0][4:0] vscale;
    logic [NCH-1:0][15:0] vpos;
    logic [4:0] hscale;
    logic [1:0] trig_src;
    logic [15:0] trig_level;
    logic trig_edge;
    logic trig_rise;
    logic trig_dc;
    logic setup_second;
    logic [31:0] delay_ns;
  } acqrh_setup_t;

endpackage : acqrh_pkg

`default_nettype wire

// file: src/acqrh_ctrl.sv
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// RL1: Run key lights run indicator and acquires and displays continuously.
// RL2: In run, while waiting for an absent trigger, display is not updated.
// RL3: Hold key in run enters hold, keeps last data, run indicator off.
// RL4: Hold makes no new acquisition but allows shifting and magnifying held data.
// RL5: Hold key in hold makes one capture, then returns to hold.
// RL6: Free-running mode lets a single capture complete without any trigger.
// RL7: Wait-for-trigger mode holds a single capture until a trigger arrives.
// RL8: Autoset displays channels with signal and hides channels without.
// RL9: Autoset treats amplitude of about 5 mV or less as no signal.
// RL10: Lowest signal channel becomes trigger source and horizontal reference.
// RL11: Autoset picks vertical scale so amplitude spans two to five divisions.
// RL12: Autoset centres each signal's average level vertically.
// RL13: Autoset picks horizontal scale showing two to five reference cycles.
// RL14: Autoset puts trigger level at amplitude midpoint of source channel.
// RL15: No signal: all on, 100 mV/div, 1 ms/div, channel one, 0 V.
// RL16: Fallback sensitivity becomes 1 V/div at x10, 10 V/div at x100.
// RL17: Several enabled channels adjust vertical sensitivity and position.
// RL18: Autoset forces run, DC, edge, free-run, first setup, zero delay, rise.
// RL19: Panel delivers each key press as one debounced single-cycle pulse.
module acqrh_ctrl
  import acqrh_pkg::*;
#(
  parameter int AUTO_WAIT_CYCLES = AUTO_CYCLES
)
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // APB slave
  input wire logic [7:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Panel keys
  input wire logic i_run_key,
  input wire logic i_hold_single_key,
  input wire logic i_autoset_key,
  // Acquisition engine
  input wire logic i_trigger,
  input wire logic i_capture_done,
  output logic o_capture_start,
  output logic o_capture_abort,
  output logic o_display_update,
  // Channel measurement engine
  input wire logic i_meas_done,
  input wire acqrh_meas_t i_meas,
  output logic o_meas_start,
  // Status and panel setup
  output logic o_run_led,
  output logic o_held,
  output acqrh_setup_t o_setup
);

  if (AUTO_WAIT_CYCLES < 2 || AUTO_WAIT_CYCLES > 16777215)
  begin : g_bad_wait
    $error("acqrh_ctrl: AUTO_WAIT_CYCLES out of range");
  end

  // ************
  // Helper functions
  // ************
  function automatic logic addr_mapped(input logic [7:0] addr);
    return addr inside {ADDR_CTRL, ADDR_STATUS, ADDR_CHAN, ADDR_VSCALE, ADDR_VPOS01,
                        ADDR_VPOS23, ADDR_HSCALE, ADDR_TRIG_LEVEL};
  endfunction : addr_mapped

  function automatic logic [4:0] probe_steps(input logic [1:0] probe);
    case (probe)
      PROBE_X10: return PROBE_STEP;
      PROBE_X100: return 5'(PROBE_STEP + PROBE_STEP);
      default: return 5'h00;
    endcase
  endfunction : probe_steps

  function automatic logic [4:0] sat_code(input logic [4:0] base, input logic [4:0] add);
    logic [5:0] sum;
    sum = {1'b0, base} + {1'b0, add};
    return (sum > {1'b0, VCODE_MAX}) ? VCODE_MAX : sum[4:0];
  endfunction : sat_code

  // Lane offset in millivolts at the tip scales with the probe
  function automatic logic [15:0] lane_pos(input int ch, input logic [1:0] probe);
    int mult;
    mult = (probe == PROBE_X10) ? 10 : ((probe == PROBE_X100) ? 100 : 1);
    return 16'(int'(LANE_POS_MV[ch]) * mult);
  endfunction : lane_pos

  function automatic logic [2:0] count_ones(input logic [NCH-1:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int k = 0; k < NCH; k++)
    begin
      n = 3'(n + {2'h0, v[k]});
    end
    return n;
  endfunction : count_ones

  function automatic logic [1:0] lowest_set(input logic [NCH-1:0] v);
    logic [1:0] idx;
    idx = 2'h0;
    for (int k = NCH - 1; k >= 0; k--)
    begin
      if (v[k])
      begin
        idx = 2'(k);
      end
    end
    return idx;
  endfunction : lowest_set

  // ************
  // Declarations
  // ************
  acqrh_state_t state_reg;
  acqrh_state_t state_next;
  logic trig_wait_reg;
  logic [NCH-1:0][1:0] probe_reg;
  logic sw_run_reg;
  logic sw_hold_reg;
  logic sw_auto_reg;
  logic [23:0] wait_cnt_reg;
  acqrh_meas_t meas_reg;
  logic apb_access;
  logic apb_done;
  logic run_press;
  logic hold_press;
  logic auto_press;
  logic in_run;
  logic in_arm;
  logic in_capt;
  logic auto_busy;
  logic arm_fire;
  logic [NCH-1:0] present;
  logic [2:0] n_present;
  logic [1:0] ref_ch;
  logic [1:0] vadj;
  logic [NCH-1:0][4:0] vpick;
  logic [4:0] hpick;
  logic [16:0] amp [NCH];
  logic [16:0] level_sum;

  // ************
  // APB slave
  // ************
  // One wait state: pready rises in the second access cycle
  assign apb_access = i_psel & i_penable & ~o_pready;
  assign apb_done = i_psel & i_penable & o_pready;

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end
    else
    begin
      o_pready <= apb_access;
      o_pslverr <= apb_access & ~addr_mapped(i_paddr);
      o_prdata <= 32'h0000_0000;
      if (apb_access && !i_pwrite)
      begin
        case (i_paddr)
          ADDR_CTRL:
            o_prdata <= 32'({probe_reg, 3'h0, trig_wait_reg});
          ADDR_STATUS:
          begin
            o_prdata[STAT_STATE_LSB +: 3] <= state_reg;
            o_prdata[STAT_RUN_LED_BIT] <= o_run_led;
            o_prdata[STAT_AUTO_BUSY_BIT] <= auto_busy;
            o_prdata[STAT_HELD_BIT] <= o_held;
          end
          ADDR_CHAN:
          begin
            o_prdata[CHAN_DISP_LSB +: NCH] <= o_setup.disp_en;
            o_prdata[CHAN_DC_LSB +: NCH] <= o_setup.dc_coupling;
            o_prdata[CHAN_TSRC_LSB +: 2] <= o_setup.trig_src;
            o_prdata[CHAN_EDGE_BIT] <= o_setup.trig_edge;
            o_prdata[CHAN_RISE_BIT] <= o_setup.trig_rise;
            o_prdata[CHAN_TDC_BIT] <= o_setup.trig_dc;
            o_prdata[CHAN_SECOND_BIT] <= o_setup.setup_second;
          end
          ADDR_VSCALE:
            o_prdata <= {3'h0, o_setup.vscale[3], 3'h0, o_setup.vscale[2],
                         3'h0, o_setup.vscale[1], 3'h0, o_setup.vscale[0]};
          ADDR_VPOS01:
            o_prdata <= {o_setup.vpos[1], o_setup.vpos[0]};
          ADDR_VPOS23:
            o_prdata <= {o_setup.vpos[3], o_setup.vpos[2]};
          ADDR_HSCALE:
            o_prdata <= 32'(o_setup.hscale);
          ADDR_TRIG_LEVEL:
            o_prdata <= 32'(o_setup.trig_level);
          default:
            o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Writes land only at the completing edge; key bits act as one-cycle pulses
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      trig_wait_reg <= CTRL_TRIG_WAIT_RESET;
      probe_reg <= '0;
      sw_run_reg <= 1'b0;
      sw_hold_reg <= 1'b0;
      sw_auto_reg <= 1'b0;
    end
    else
    begin
      sw_run_reg <= 1'b0;
      sw_hold_reg <= 1'b0;
      sw_auto_reg <= 1'b0;
      if (apb_done && i_pwrite && i_paddr == ADDR_CTRL)
      begin
        if (i_pstrb[0])
        begin
          trig_wait_reg <= i_pwdata[CTRL_TRIG_WAIT_BIT];
          sw_run_reg <= i_pwdata[CTRL_RUN_BIT];
          sw_hold_reg <= i_pwdata[CTRL_HOLD_BIT];
          sw_auto_reg <= i_pwdata[CTRL_AUTO_BIT];
          probe_reg[1:0] <= i_pwdata[CTRL_PROBE_LSB +: 4];
        end
        if (i_pstrb[1])
        begin
          probe_reg[3:2] <= i_pwdata[CTRL_PROBE_LSB + 4 +: 4];
        end
      end
      // Autoset overrides a software write of the wait bit in the same cycle
      if (state_reg == ACQ_AUTO_APPLY)
      begin
        trig_wait_reg <= 1'b0; // see RL18
      end
    end
  end

  // ************
  // Acquisition sequencing
  // ************
  // Each key pulse is taken once; held keys would retrigger single shots
  assign run_press = i_run_key | sw_run_reg; // see RL19
  assign hold_press = i_hold_single_key | sw_hold_reg;
  assign auto_press = i_autoset_key | sw_auto_reg;
  assign in_run = (state_reg == ACQ_RUN_ARM) || (state_reg == ACQ_RUN_CAPT);
  assign in_arm = (state_reg == ACQ_RUN_ARM) || (state_reg == ACQ_SNG_ARM);
  assign in_capt = (state_reg == ACQ_RUN_CAPT) || (state_reg == ACQ_SNG_CAPT);
  assign auto_busy = (state_reg == ACQ_AUTO_MEAS) || (state_reg == ACQ_AUTO_APPLY);
  assign arm_fire = i_trigger // see RL7
                    || (!trig_wait_reg && wait_cnt_reg == 24'(AUTO_WAIT_CYCLES - 1)); // see RL6

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wait_cnt_reg <= 24'h00_0000;
    end
    else if (in_arm && !arm_fire)
    begin
      wait_cnt_reg <= 24'(wait_cnt_reg + 24'h00_0001);
    end
    else
    begin
      wait_cnt_reg <= 24'h00_0000;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ACQ_RUN_ARM:
        if (arm_fire) state_next = ACQ_RUN_CAPT; // see RL2
      ACQ_RUN_CAPT:
        if (i_capture_done) state_next = ACQ_RUN_ARM; // see RL1
      ACQ_HOLD:
        state_next = ACQ_HOLD; // see RL4
      ACQ_SNG_ARM:
        if (arm_fire) state_next = ACQ_SNG_CAPT;
      ACQ_SNG_CAPT:
        if (i_capture_done) state_next = ACQ_HOLD; // see RL5
      ACQ_AUTO_MEAS:
        if (i_meas_done) state_next = ACQ_AUTO_APPLY;
      ACQ_AUTO_APPLY:
        state_next = ACQ_RUN_ARM; // see RL18
      default:
        state_next = ACQ_RUN_ARM;
    endcase
    // Keys are ignored while autoset is busy so its result is not torn
    if (!auto_busy)
    begin
      if (auto_press)
      begin
        state_next = ACQ_AUTO_MEAS;
      end
      else if (run_press && !in_run)
      begin
        state_next = ACQ_RUN_ARM; // see RL1
      end
      else if (hold_press && in_run)
      begin
        state_next = ACQ_HOLD; // see RL3
      end
      else if (hold_press && state_reg == ACQ_HOLD)
      begin
        state_next = ACQ_SNG_ARM; // see RL5
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_reg <= ACQ_RUN_ARM;
      o_run_led <= 1'b1;
      o_held <= 1'b0;
      o_capture_start <= 1'b0;
      o_capture_abort <= 1'b0;
      o_display_update <= 1'b0;
      o_meas_start <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      o_run_led <= (state_next == ACQ_RUN_ARM) || (state_next == ACQ_RUN_CAPT); // see RL3
      o_held <= (state_next == ACQ_HOLD); // see RL4
      o_capture_start <= in_arm && (state_next == ACQ_RUN_CAPT || state_next == ACQ_SNG_CAPT);
      o_capture_abort <= in_capt && !i_capture_done && !(state_next == state_reg);
      // Only a finished capture refreshes the screen
      o_display_update <= in_capt && i_capture_done; // see RL2
      o_meas_start <= (state_next == ACQ_AUTO_MEAS) && !auto_busy;
    end
  end

  // ************
  // Autoset evaluation
  // ************
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      meas_reg <= '0;
    end
    else if (state_reg == ACQ_AUTO_MEAS && i_meas_done)
    begin
      meas_reg <= i_meas;
    end
  end

  for (genvar c = 0; c < NCH; c++)
  begin : g_chan
    assign amp[c] = 17'({meas_reg[c].vmax[15], meas_reg[c].vmax}
                        - {meas_reg[c].vmin[15], meas_reg[c].vmin});
    // Negative spans mean no usable measurement
    assign present[c] = !amp[c][16] && (amp[c][15:0] > NOSIG_MV); // see RL9

    acqrh_step_pick #(
      .BASE(V_BASE_IDX),
      .NCODES(V_PICK_CODES)
    ) u_vpick (
      .i_target({16'h0000, amp[c][15:0]}),
      .o_code(vpick[c])
    ); // see RL11
  end

  assign n_present = count_ones(present);
  assign ref_ch = lowest_set(present); // see RL10
  // Coarser steps leave room for stacked traces
  assign vadj = (n_present >= 3'h3) ? 2'h2 : ((n_present == 3'h2) ? 2'h1 : 2'h0); // see RL17
  assign level_sum = 17'({meas_reg[ref_ch].vmax[15], meas_reg[ref_ch].vmax}
                         + {meas_reg[ref_ch].vmin[15], meas_reg[ref_ch].vmin});

  acqrh_step_pick #(
    .BASE(H_BASE_IDX),
    .NCODES(H_PICK_CODES)
  ) u_hpick (
    .i_target(meas_reg[ref_ch].period_ns),
    .o_code(hpick)
  ); // see RL13

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_setup <= '0;
      o_setup.disp_en <= '1;
      o_setup.dc_coupling <= '1;
      o_setup.hscale <= HCODE_DEF;
      o_setup.trig_edge <= 1'b1;
      o_setup.trig_rise <= 1'b1;
      o_setup.trig_dc <= 1'b1;
      for (int c = 0; c < NCH; c++)
      begin
        o_setup.vscale[c] <= VCODE_DEF;
        o_setup.vpos[c] <= lane_pos(c, PROBE_X1);
      end
    end
    else if (state_reg == ACQ_AUTO_APPLY)
    begin
      o_setup.dc_coupling <= '1; // see RL18
      o_setup.trig_edge <= 1'b1;
      o_setup.trig_rise <= 1'b1;
      o_setup.trig_dc <= 1'b1;
      o_setup.setup_second <= 1'b0;
      o_setup.delay_ns <= 32'h0000_0000;
      if (|present)
      begin
        o_setup.disp_en <= present; // see RL8
        o_setup.hscale <= hpick;
        o_setup.trig_src <= ref_ch; // see RL10
        o_setup.trig_level <= level_sum[16:1]; // see RL14
        for (int c = 0; c < NCH; c++)
        begin
          o_setup.vscale[c] <= sat_code(sat_code(vpick[c], probe_steps(probe_reg[c])),
                                        {3'h0, vadj}); // see RL17
          // Average goes to screen centre, spread into lanes when stacked
          o_setup.vpos[c] <= 16'(-meas_reg[c].vavg // see RL12
                             + ((n_present > 3'h1) ? lane_pos(c, probe_reg[c]) : 16'h0000));
        end
      end
      else
      begin
        o_setup.disp_en <= '1; // see RL15
        o_setup.hscale <= HCODE_DEF;
        o_setup.trig_src <= 2'h0;
        o_setup.trig_level <= 16'h0000;
        for (int c = 0; c < NCH; c++)
        begin
          o_setup.vscale[c] <= sat_code(VCODE_DEF, probe_steps(probe_reg[c])); // see RL16
          o_setup.vpos[c] <= lane_pos(c, probe_reg[c]);
        end
      end
    end
  end

endmodule : acqrh_ctrl

`default_nettype wire

// file: src/acqrh_step_pick.sv
`timescale 1ns/100ps
`default_nettype none

module acqrh_step_pick
#(
  parameter int BASE = 0,
  parameter int NCODES = 11
)
(
  // Quantity to fit within five divisions
  input wire logic [31:0] i_target,
  // Smallest code whose five divisions cover the target
  output logic [4:0] o_code
);

  if (NCODES < 1 || NCODES > 32 || BASE < 0 || BASE + NCODES > 30)
  begin : g_bad_param
    $error("acqrh_step_pick: unsupported table size");
  end

  // Value of 1-2-5 index: mantissa 1,2,5 times ten to the index over three
  function automatic logic [39:0] step_value(input int idx);
    logic [39:0] val;
    int k;
    val = (idx % 3 == 0) ? 40'h00_0000_0001 : ((idx % 3 == 1) ? 40'h00_0000_0002 :
          40'h00_0000_0005);
    for (k = 0; k < 10; k++)
    begin
      if (k < idx / 3)
      begin
        val = 40'(val * 40'h00_0000_000a);
      end
    end
    return val;
  endfunction : step_value

  // Saturates at the coarsest code when nothing fits
  always_comb
  begin
    o_code = 5'(NCODES - 1);
    for (int c = NCODES - 1; c >= 0; c--)
    begin
      if (40'(step_value(c + BASE) * 40'h00_0000_0005) >= {8'h00, i_target})
      begin
        o_code = 5'(c);
      end
    end
  end

endmodule : acqrh_step_pick

`default_nettype wire

// file: testbench/acqrh_chk.sv
`timescale 1ns/100ps
`default_nettype none

module acqrh_chk
  import acqrh_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Register bus
  input wire logic i_penable,
  input wire logic o_pready,
  // Keys and engines
  input wire logic i_run_key,
  input wire logic i_hold_single_key,
  input wire logic i_autoset_key,
  input wire logic i_capture_done,
  input wire logic i_meas_done,
  input wire logic o_capture_start,
  input wire logic o_display_update,
  input wire logic o_meas_start,
  input wire logic o_run_led,
  input wire logic o_held
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);

  a_run_key_led: assert property (i_run_key && o_held && !i_autoset_key
    |=> o_run_led && !o_held) else $error("run key ignored in hold");
  a_hold_from_run: assert property (
    i_hold_single_key && o_run_led && !i_run_key && !i_autoset_key |=> o_held && !o_run_led)
    else $error("hold key did not hold");
  a_single_start: assert property (
    i_hold_single_key && o_held && !i_run_key && !i_autoset_key |=> !o_held && !o_run_led)
    else $error("hold key in hold gave no single shot");
  a_held_no_start: assert property (o_held && $past(o_held) |-> !o_capture_start)
    else $error("capture started while held");
  a_update_cause: assert property (o_display_update |-> $past(i_capture_done))
    else $error("display update without finished capture");
  a_single_returns: assert property (
    o_display_update && !o_run_led && !$past(o_run_led) |-> ##[0:1] o_held)
    else $error("single shot did not return to hold");
  a_autoset_meas: assert property (
    i_autoset_key && (o_run_led || o_held) |=> o_meas_start) else $error("no measurement");
  a_led_cause: assert property ($rose(o_run_led)
    |-> $past(i_run_key) || $past(i_meas_done, 2) || $past(o_pready, 2))
    else $error("run lamp lit without cause");
  a_pready_wait: assert property (i_penable && !$past(i_penable) |-> !o_pready ##1 o_pready)
    else $error("bus answer not after one wait state");

  c_single: cover property (o_held ##1 !o_held ##[1:40] o_display_update);
  c_autoset: cover property (o_meas_start ##[1:8] $rose(o_run_led));
  c_hold: cover property (o_run_led ##1 o_held);
endmodule : acqrh_chk

bind acqrh_ctrl acqrh_chk i_chk (.i_mclk, .i_reset_n, .i_penable, .o_pready, .i_run_key,
  .i_hold_single_key, .i_autoset_key, .i_capture_done, .i_meas_done, .o_capture_start,
  .o_display_update, .o_meas_start, .o_run_led, .o_held);

`default_nettype wire

// file: testbench/acqrh_panel.sv
`timescale 1ns/100ps
`default_nettype none

module acqrh_panel
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // User presses, and a slow finger adding one cycle
  input wire logic [2:0] i_press,
  input wire logic i_slow,
  // Debounced keys
  output logic o_run_key,
  output logic o_hold_single_key,
  output logic o_autoset_key
);
  logic [2:0] press_reg;

  // One press leaves as one clean pulse, so no bounce can double a transition
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      press_reg <= 3'h0;
      {o_autoset_key, o_hold_single_key, o_run_key} <= 3'h0;
    end
    else
    begin
      press_reg <= i_slow ? i_press : 3'h0;
      {o_autoset_key, o_hold_single_key, o_run_key} <= i_slow ? press_reg : i_press;
    end
  end
endmodule : acqrh_panel

`default_nettype wire

// file: testbench/test_acquisition_run_hold_control.sv
`timescale 1ns/100ps
`default_nettype none

module test_acquisition_run_hold_control
  import acqrh_pkg::*;
;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0, pen = 1'h0, pwr = 1'h0, trig = 1'h0, cdone = 1'h0, mdone = 1'h0;
  logic slow = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] rd, prdata;
  logic [2:0] press = 3'h0;
  logic pready, pslverr, err, rk, hk, ak, cstart, upd, mstart, led, held;
  acqrh_meas_t meas = '0;
  int bad_count = 0, n_compared = 0, n_upd = 0, n_st = 0, seed = 15, n0, amp, a3, lo, per;

  initial forever #4 clk = ~clk;

  acqrh_ctrl #(.AUTO_WAIT_CYCLES(8)) i_dut (
    .i_mclk(clk), .i_reset_n(rst_n), .i_paddr(paddr), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_pwdata(pwdata), .i_pstrb(4'hf), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_run_key(rk), .i_hold_single_key(hk), .i_autoset_key(ak),
    .i_trigger(trig), .i_capture_done(cdone), .o_capture_start(cstart), .o_capture_abort(),
    .o_display_update(upd), .i_meas_done(mdone), .i_meas(meas), .o_meas_start(mstart),
    .o_run_led(led), .o_held(held), .o_setup());
  acqrh_panel i_panel (.i_mclk(clk), .i_reset_n(rst_n), .i_press(press), .i_slow(slow),
    .o_run_key(rk), .o_hold_single_key(hk), .o_autoset_key(ak));

  // Engines answer one cycle after each request
  always @(posedge clk)
  begin
    cdone <= cstart;
    mdone <= mstart;
    n_upd <= n_upd + int'(upd === 1'h1);
    n_st <= n_st + int'(cstart === 1'h1);
  end

  function automatic longint s125(input int k);
    longint m = 1;
    repeat (k / 3) m *= 10;
    return m * ((k % 3 == 0) ? 1 : ((k % 3 == 1) ? 2 : 5));
  endfunction : s125

  function automatic logic [4:0] pick(input int x, input int base, input int n);
    for (int k = 0; k < n; k++)
      if (5 * s125(k + base) >= x) return 5'(k);
    return 5'(n - 1);
  endfunction : pick

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    paddr <= a;
    pwr <= w;
    pwdata <= d;
    psel <= 1'h1;
    @(posedge clk) pen <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'h0, 32'h0);
    chk(rd, e);
  endtask : rchk

  task automatic key(input logic [2:0] k);
    slow <= 1'($random(seed));
    press <= k;
    @(posedge clk) press <= 3'h0;
    repeat (8) @(posedge clk);
  endtask : key

  task automatic fchk(input logic [1:0] e);
    @(negedge clk);
    chk({30'h0, held, led}, {30'h0, e});
    @(posedge clk);
  endtask : fchk

  task automatic uwait(input int want);
    for (int i = 0; i < 200 && n_upd < want; i++) @(posedge clk);
  endtask : uwait

  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // The tests need a few hundred cycles; this leaves a wide margin
  initial
  begin
    #200_000;
    bad_count++;
    close_out;
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    fchk(2'h1);
    rchk(ADDR_VSCALE, 32'h0505_0505);
    rchk(ADDR_CHAN, 32'h0000_1cff);
    rchk(8'h20, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    n0 = n_upd;
    uwait(n0 + 2);
    chk(32'(n_upd >= n0 + 2), 32'h0000_0001);
    $display("test reset_run done");
    apb(ADDR_CTRL, 1'h1, 32'h0000_0001);
    repeat (12) @(posedge clk);
    n0 = n_upd;
    repeat (40) @(posedge clk);
    chk(32'(n_upd - n0), 32'h0000_0000);
    trig <= 1'h1;
    @(posedge clk) trig <= 1'h0;
    uwait(n0 + 1);
    chk(32'(n_upd - n0), 32'h0000_0001);
    key(3'h2);
    fchk(2'h2);
    n0 = n_st;
    repeat (40) @(posedge clk) trig <= 1'($random(seed));
    @(posedge clk) trig <= 1'h0;
    chk(32'(n_st - n0), 32'h0000_0000);
    $display("test run_hold done");
    key(3'h2);
    fchk(2'h0);
    n0 = n_upd;
    repeat (30) @(posedge clk);
    chk(32'(n_upd - n0), 32'h0000_0000);
    trig <= 1'h1;
    @(posedge clk) trig <= 1'h0;
    uwait(n0 + 1);
    repeat (2) @(posedge clk);
    fchk(2'h2);
    apb(ADDR_CTRL, 1'h1, 32'h0000_0000);
    n0 = n_upd;
    key(3'h2);
    uwait(n0 + 1);
    repeat (2) @(posedge clk);
    chk(32'(n_upd - n0), 32'h0000_0001);
    fchk(2'h2);
    key(3'h1);
    fchk(2'h1);
    $display("test single done");
    apb(ADDR_CTRL, 1'h1, 32'h0000_0241);
    for (int c = 0; c < NCH; c++) meas[c] <= '{16'sh0105, 16'sh0100, 16'sh0100, 32'h0000_03e8};
    key(3'h4);
    fchk(2'h1);
    rchk(ADDR_CHAN, 32'h0000_1cff);
    rchk(ADDR_VSCALE, 32'h050b_0805);
    rchk(ADDR_HSCALE, 32'h0000_0012);
    rchk(ADDR_TRIG_LEVEL, 32'h0000_0000);
    rchk(ADDR_CTRL, 32'h0000_0240);
    $display("test autoset_empty done");
    apb(ADDR_CTRL, 1'h1, 32'h0000_0001);
    amp = 6 + {$random(seed)} % 20000;
    a3 = 6 + {$random(seed)} % 50;
    lo = {$random(seed)} % 500;
    per = 2 + {$random(seed)} % 400_000_000;
    meas[0] <= '{16'(lo + 5), 16'(lo), 16'(lo), 32'h0000_0001};
    meas[1] <= '{16'(lo + amp), 16'(lo), 16'(lo), 32'(per)};
    meas[2] <= '0;
    meas[3] <= '{16'(lo + a3), 16'(lo), 16'(lo), 32'h0000_0064};
    key(3'h4);
    rchk(ADDR_CHAN, 32'h0000_1dfa);
    apb(ADDR_VSCALE, 1'h0, 32'h0);
    chk({27'h0, rd[12:8]}, {27'h0, pick(amp, V_BASE_IDX, V_PICK_CODES) + 5'h01});
    chk({27'h0, rd[28:24]}, {27'h0, pick(a3, V_BASE_IDX, V_PICK_CODES) + 5'h01});
    rchk(ADDR_HSCALE, {27'h0, pick(per, H_BASE_IDX, H_PICK_CODES)});
    apb(ADDR_VPOS01, 1'h0, 32'h0);
    chk({16'h0, rd[31:16]}, {16'h0, 16'(100 - lo)});
    apb(ADDR_TRIG_LEVEL, 1'h0, 32'h0);
    chk({16'h0, rd[15:0]}, 32'(lo + amp / 2));
    rchk(ADDR_CTRL, 32'h0000_0000);
    $display("test autoset_signal done");
    close_out;
  end
endmodule : test_acquisition_run_hold_control

`default_nettype wire
